// ---- hdl/rsr_top.sv ----
/*
 * Reset cause and enable register with its reset sequencer.
 * Assumes the core reaches the register over an 8-bit special function
 * register bus on i_clk_sys, that watchdog, flash fault and USB event
 * inputs are single-cycle pulses on the same clock, and that pin,
 * supply monitor, comparator, bus supply and monitored clock inputs are
 * asynchronous levels.
 */
`timescale 1ns/1ns
`default_nettype none

module rsr_top (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    input wire logic i_rst_pin_n,
    input wire logic i_vdd_ok,
    input wire logic i_cmp0_out,
    input wire logic i_vbus,
    input wire logic i_clk_mon,
    input wire logic i_usb_bus_reset,
    input wire logic i_usb_fn_en,
    input wire logic i_wdt_overflow,
    input wire logic i_flash_error,
    output logic [7:0] o_sfr_rdata,
    output logic o_sys_rst_n
);
    import rsr_pkg::*;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_HOLD_CYC - 1);

    rsr_state_t state_q;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic [7:0] flags_q;
    logic [7:0] en_q;
    logic [7:0] cause_d;
    logic [SYNC_W-1:0] sync_s;
    logic vbus_q;
    logic vbus_edge;
    logic mcd_timeout;
    logic run;
    logic addr_hit;
    logic wr_hit;
    logic sw_wr;
    logic usb_event;

    // ------------------------------------------------------------------
    // Input synchronisers and missing clock detector
    // ------------------------------------------------------------------
    rsr_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async({i_clk_mon, i_vbus, i_cmp0_out, i_vdd_ok, i_rst_pin_n}),
        .o_sync(sync_s)
    );

    rsr_mcd u_mcd (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_enable(en_q[MCD_BIT]),
        .i_mon_lvl(sync_s[SY_MON]),
        .o_timeout(mcd_timeout)
    );

    // Bus supply edges are seen in the same cycle that the synchroniser output changes.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            vbus_q <= 1'b0;
        end else begin
            vbus_q <= sync_s[SY_VBUS];
        end
    end

    assign vbus_edge = sync_s[SY_VBUS] ^ vbus_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign run = (state_q == ST_RUN);

    // The address is decoded in full; there is no page select.
    always_comb begin
        addr_hit = 1'b0;
        if (i_sfr_addr == RCE_ADDR) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    end

    assign wr_hit = run && i_sfr_wr && addr_hit;
    assign sw_wr = wr_hit && i_sfr_wdata[SW_BIT];
    assign usb_event = (i_usb_bus_reset && i_usb_fn_en) || vbus_edge;

    // ------------------------------------------------------------------
    // Cause selection
    // ------------------------------------------------------------------
    // Only one cause is chosen per reset, the pin taking precedence.
    always_comb begin
        cause_d = 8'h00;
        if (!run) begin
            cause_d = 8'h00;
        end else if (!sync_s[SY_PIN]) begin
            cause_d = FLAG_PIN;
        end else if (en_q[POR_BIT] && !sync_s[SY_VDD]) begin
            cause_d = FLAG_POR;
        end else if (en_q[MCD_BIT] && mcd_timeout) begin
            cause_d = FLAG_MCD;
        end else if (en_q[CMP_BIT] && !sync_s[SY_CMP]) begin
            cause_d = FLAG_CMP;
        end else if (i_wdt_overflow) begin
            cause_d = FLAG_WDT;
        end else if (i_flash_error) begin
            cause_d = FLAG_FLASH;
        end else if (sw_wr) begin
            cause_d = FLAG_SW;
        end else if (en_q[USB_BIT] && usb_event) begin
            cause_d = FLAG_USB;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    // Power-on starts in the hold state so the system sees a full pulse.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_HOLD;
            hold_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    hold_cnt_q <= '0;
                    if (cause_d == FLAG_PIN) begin
                        state_q <= ST_PIN;
                    end else if (cause_d != 8'h00) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_PIN: begin
                    hold_cnt_q <= '0;
                    if (sync_s[SY_PIN]) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt_q == HOLD_LAST) begin
                        state_q <= ST_RUN;
                        hold_cnt_q <= '0;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + HOLD_W'(1);
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                    hold_cnt_q <= '0;
                end
            endcase
        end
    end

    // The reset goes to the core only; the reset pin is never driven.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sys_rst_n <= 1'b0;
        end else if (run && cause_d != 8'h00) begin
            o_sys_rst_n <= 1'b0;
        end else if (state_q == ST_HOLD && hold_cnt_q == HOLD_LAST) begin
            o_sys_rst_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Power-on leaves only the power-on flag set.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_q <= FLAGS_RESET;
        end else if (cause_d != 8'h00) begin
            flags_q <= cause_d;
        end
    end

    // Enables fall back to off on every system reset.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            en_q <= EN_RESET;
        end else if (!run || cause_d != 8'h00) begin
            en_q <= EN_RESET;
        end else if (wr_hit) begin
            en_q <= i_sfr_wdata & EN_MASK;
        end
    end

    // Reads return the cause flags, never the enables.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sfr_rdata <= RDATA_RESET;
        end else if (run && i_sfr_rd && addr_hit) begin
            o_sfr_rdata <= flags_q;
        end else begin
            o_sfr_rdata <= RDATA_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    sequence hold_low_s;
        (!o_sys_rst_n)[*8] ##1 (!o_sys_rst_n)[*2];
    endsequence

    sequence sw_request_s;
        run && sw_wr;
    endsequence

    sequence sw_result_s;
        !o_sys_rst_n && state_q != ST_RUN;
    endsequence

    sw_force_a: assert property (
        sw_request_s |=> sw_result_s)
        else $error("software write did not force reset");

    sw_flag_a: assert property (
        (sw_request_s ##0 cause_d == FLAG_SW) |=> flags_q == FLAG_SW
        ##[1:20] o_sys_rst_n && flags_q == FLAG_SW)
        else $error("software cause flag wrong after reset");

    hold_len_a: assert property (
        ($fell(o_sys_rst_n) && state_q == ST_HOLD)
        |-> hold_low_s ##1 o_sys_rst_n)
        else $error("system reset pulse length wrong");

    usb_reset_a: assert property (
        (run && en_q[USB_BIT] && i_usb_bus_reset && i_usb_fn_en)
        |=> !o_sys_rst_n)
        else $error("usb bus reset ignored");

    usb_off_a: assert property (
        (run && !en_q[USB_BIT] && cause_d == 8'h00) |=> o_sys_rst_n)
        else $error("reset without an enabled cause");

    cmp_reset_a: assert property (
        (run && en_q[CMP_BIT] && !sync_s[SY_CMP]) |=> !o_sys_rst_n)
        else $error("comparator low did not reset");

    wdt_reset_a: assert property (
        (run && i_wdt_overflow) |=> !o_sys_rst_n)
        else $error("watchdog overflow did not reset");

    flash_flag_a: assert property (
        (cause_d == FLAG_FLASH) |=> flags_q == FLAG_FLASH && !o_sys_rst_n)
        else $error("flash fault flag not recorded");

    mcd_reset_a: assert property (
        (run && en_q[MCD_BIT] && mcd_timeout && sync_s[SY_PIN]
        && !(en_q[POR_BIT] && !sync_s[SY_VDD]))
        |=> !o_sys_rst_n && flags_q == FLAG_MCD)
        else $error("missing clock did not reset");

    vdd_reset_a: assert property (
        (run && sync_s[SY_PIN] && en_q[POR_BIT] && !sync_s[SY_VDD])
        |=> flags_q == FLAG_POR && !o_sys_rst_n)
        else $error("supply monitor reset not recorded");

    pin_reset_a: assert property (
        (run && !sync_s[SY_PIN])
        |=> state_q == ST_PIN && flags_q == FLAG_PIN)
        else $error("pin reset not recorded");

    pin_hold_a: assert property (
        (state_q == ST_PIN && !sync_s[SY_PIN])
        |=> state_q == ST_PIN && !o_sys_rst_n)
        else $error("pin reset released while pin low");

    en_clear_a: assert property (
        !run |-> en_q == EN_RESET)
        else $error("enables kept through a system reset");

    addr_miss_a: assert property (
        (i_sfr_wr && !addr_hit && run && cause_d == 8'h00)
        |=> en_q == $past(en_q))
        else $error("write to other address changed enables");

    read_back_a: assert property (
        (run && i_sfr_rd && addr_hit) |=> o_sfr_rdata == $past(flags_q))
        else $error("read data not the cause flags");

    one_cause_a: assert property (
        $onehot(flags_q))
        else $error("more than one cause flag set");

endmodule

`default_nettype wire

// ---- hdl/rsr_pkg.sv ----
/*
 * Constants, field positions, timing counts and types shared by the
 * reset cause and enable register block.
 * Assumes a single 25 MHz system clock and an 8-bit special function
 * register bus on the core side.
 */


package rsr_pkg;

    // ------------------------------------------------------------------
    // Register address and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] RCE_ADDR = 8'hEF;
    localparam int USB_BIT = 7;
    localparam int FLASH_BIT = 6;
    localparam int CMP_BIT = 5;
    localparam int SW_BIT = 4;
    localparam int WDT_BIT = 3;
    localparam int MCD_BIT = 2;
    localparam int POR_BIT = 1;
    localparam int PIN_BIT = 0;
    localparam logic [7:0] FLAG_USB = 8'h80;
    localparam logic [7:0] FLAG_FLASH = 8'h40;
    localparam logic [7:0] FLAG_CMP = 8'h20;
    localparam logic [7:0] FLAG_SW = 8'h10;
    localparam logic [7:0] FLAG_WDT = 8'h08;
    localparam logic [7:0] FLAG_MCD = 8'h04;
    localparam logic [7:0] FLAG_POR = 8'h02;
    localparam logic [7:0] FLAG_PIN = 8'h01;
    localparam logic [7:0] EN_MASK = 8'hA6;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h02;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned RST_HOLD_NS = 400;
    localparam int unsigned RST_HOLD_CYC =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MCD_TIMEOUT_NS = 1000;
    localparam int unsigned MCD_TIMEOUT_CYC =
        (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W = 4;
    localparam int MCD_W = 8;
    localparam int SYNC_W = 5;
    localparam int SY_PIN = 0;
    localparam int SY_VDD = 1;
    localparam int SY_CMP = 2;
    localparam int SY_VBUS = 3;
    localparam int SY_MON = 4;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_HOLD = 3'b010,
        ST_PIN = 3'b100
    } rsr_state_t;

endpackage

// ---- hdl/rsr_sync.sv ----
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs are asynchronous levels; the outputs are quiet low
 * during reset.
 */
`timescale 1ns/1ns
`default_nettype none

module rsr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    meta_q[gi] <= 1'b0;
                    o_sync[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= i_async[gi];
                    o_sync[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- hdl/rsr_mcd.sv ----
/*
 * Missing clock detector: flags a level that stops toggling.
 * Assumes the monitored clock arrives already synchronised as a level
 * and that the enable is cleared by the sequencer on every reset.
 */
`timescale 1ns/1ns
`default_nettype none

module rsr_mcd (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_enable,
    input wire logic i_mon_lvl,
    output logic o_timeout
);
    import rsr_pkg::*;

    localparam logic [MCD_W-1:0] LIMIT = MCD_W'(MCD_TIMEOUT_CYC);

    logic last_q;
    logic [MCD_W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Stall counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            last_q <= 1'b0;
        end else begin
            last_q <= i_mon_lvl;
        end
    end

    // The count restarts on every edge of the monitored level.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= '0;
        end else if (!i_enable || (i_mon_lvl != last_q)) begin
            cnt_q <= '0;
        end else if (cnt_q != LIMIT) begin
            cnt_q <= cnt_q + MCD_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= i_enable && (cnt_q == LIMIT);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    mcd_fire_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_enable && cnt_q == LIMIT) |=> o_timeout)
        else $error("missing clock timeout not raised");

    mcd_quiet_a: assert property (
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !i_enable |=> !o_timeout)
        else $error("timeout raised while detector disabled");

endmodule

`default_nettype wire

// ---- bench/rsr_top_test.sv ----
/*
 * Self-checking bench for the reset cause and enable register block.
 * Assumes the block is reached only through its register strobes and
 * that the bench itself plays every reset source at the ports.
 */
`timescale 1ns/1ns
`default_nettype none

module rsr_top_test;
    import rsr_pkg::*;

    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] i_sfr_addr = 8'h00;
    logic i_sfr_wr = 1'b0;
    logic [7:0] i_sfr_wdata = 8'h00;
    logic i_sfr_rd = 1'b0;
    logic i_rst_pin_n = 1'b1;
    logic i_vdd_ok = 1'b1;
    logic i_cmp0_out = 1'b1;
    logic i_vbus = 1'b0;
    logic i_clk_mon = 1'b0;
    logic i_usb_bus_reset = 1'b0;
    logic i_usb_fn_en = 1'b0;
    logic i_wdt_overflow = 1'b0;
    logic i_flash_error = 1'b0;
    logic [7:0] o_sfr_rdata;
    logic o_sys_rst_n;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;

    rsr_top dut (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_rd(i_sfr_rd),
        .i_rst_pin_n(i_rst_pin_n),
        .i_vdd_ok(i_vdd_ok),
        .i_cmp0_out(i_cmp0_out),
        .i_vbus(i_vbus),
        .i_clk_mon(i_clk_mon),
        .i_usb_bus_reset(i_usb_bus_reset),
        .i_usb_fn_en(i_usb_fn_en),
        .i_wdt_overflow(i_wdt_overflow),
        .i_flash_error(i_flash_error),
        .o_sfr_rdata(o_sfr_rdata),
        .o_sys_rst_n(o_sys_rst_n)
    );

    always #20 i_clk_sys = ~i_clk_sys;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks: %0d, errors: %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The whole sequence needs well under two thousand cycles.
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic tick(int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic check(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(logic [7:0] a, logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        tick(1);
        i_sfr_wr = 1'b0;
    endtask

    // Read data stands for exactly one cycle after the taking edge.
    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        tick(1);
        i_sfr_rd = 1'b0;
        check(o_sfr_rdata, exp);
        tick(1);
        check(o_sfr_rdata, 8'h00);
    endtask

    task automatic wait_low();
        int i;
        i = 0;
        while (o_sys_rst_n !== 1'b0 && i < 60) begin
            tick(1);
            i++;
        end
        check({7'h00, o_sys_rst_n}, 8'h00);
    endtask

    task automatic wait_run();
        int i;
        i = 0;
        while (o_sys_rst_n !== 1'b1 && i < 300) begin
            tick(1);
            i++;
        end
        check({7'h00, o_sys_rst_n}, 8'h01);
        tick(1);
    endtask

    task automatic stay_up(int k);
        logic seen;
        seen = 1'b1;
        repeat (k) begin
            tick(1);
            seen = seen & o_sys_rst_n;
        end
        check({7'h00, seen}, 8'h01);
    endtask

    task automatic cause(logic [7:0] exp);
        wait_low();
        wait_run();
        rd_chk(RCE_ADDR, exp);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        tick(12);
        i_rstn = 1'b1;
        wait_run();
        rd_chk(RCE_ADDR, FLAG_POR);
        rd_chk(8'hEE, 8'h00);
        bus_wr(8'hEE, FLAG_SW);
        stay_up(20);
        // Sources left disabled must not reset the device.
        i_cmp0_out = 1'b0;
        i_usb_fn_en = 1'b1;
        i_usb_bus_reset = 1'b1;
        i_vbus = 1'b1;
        tick(1);
        i_usb_bus_reset = 1'b0;
        stay_up(40);
        i_cmp0_out = 1'b1;
        // Software reset holds the system low for the full hold time.
        bus_wr(RCE_ADDR, FLAG_SW);
        check({7'h00, o_sys_rst_n}, 8'h00);
        n = 0;
        while (o_sys_rst_n === 1'b0 && n < 50) begin
            tick(1);
            n++;
        end
        check(8'(n), 8'(RST_HOLD_CYC));
        tick(1);
        rd_chk(RCE_ADDR, FLAG_SW);
        i_rst_pin_n = 1'b0;
        tick(6);
        check({7'h00, o_sys_rst_n}, 8'h00);
        i_rst_pin_n = 1'b1;
        cause(FLAG_PIN);
        i_wdt_overflow = 1'b1;
        tick(1);
        i_wdt_overflow = 1'b0;
        cause(FLAG_WDT);
        i_flash_error = 1'b1;
        tick(1);
        i_flash_error = 1'b0;
        cause(FLAG_FLASH);
        // Enables are written but never read back as flags.
        bus_wr(RCE_ADDR, FLAG_CMP);
        rd_chk(RCE_ADDR, FLAG_FLASH);
        i_cmp0_out = 1'b0;
        cause(FLAG_CMP);
        i_cmp0_out = 1'b1;
        bus_wr(RCE_ADDR, FLAG_MCD);
        repeat (60) begin
            i_clk_mon = ~i_clk_mon;
            tick(1);
        end
        check({7'h00, o_sys_rst_n}, 8'h01);
        cause(FLAG_MCD);
        bus_wr(RCE_ADDR, FLAG_POR);
        tick(2);
        i_vdd_ok = 1'b0;
        tick(6);
        i_vdd_ok = 1'b1;
        cause(FLAG_POR);
        bus_wr(RCE_ADDR, FLAG_USB);
        i_vbus = 1'b0;
        cause(FLAG_USB);
        // A bus reset counts only while the function is enabled.
        bus_wr(RCE_ADDR, FLAG_USB);
        i_usb_fn_en = 1'b0;
        i_usb_bus_reset = 1'b1;
        tick(1);
        i_usb_bus_reset = 1'b0;
        stay_up(20);
        i_usb_fn_en = 1'b1;
        i_usb_bus_reset = 1'b1;
        tick(1);
        i_usb_bus_reset = 1'b0;
        cause(FLAG_USB);
        // A power-on reset in mid-run restores the power-on cause alone.
        i_rstn = 1'b0;
        tick(2);
        i_rstn = 1'b1;
        wait_run();
        rd_chk(RCE_ADDR, FLAG_POR);
        i_vbus = 1'b1;
        stay_up(20);
        wrap_up();
    end
endmodule

`default_nettype wire
